// ### hdl/adcsq_top.sv
// Conversion sequencer for a successive-approximation converter
//
// Operation
// [RQ1] Start pulse high then low triggers conversion
// [RQ2] Busy flag set when conversion starts
// [RQ3] Busy flag cleared when conversion finishes
// [RQ4] Completion sets flag; request only when enabled
// [RQ5] Software may poll busy instead of interrupt
// [RQ6] Conversion clock is system clock over 2**select
// [RQ7] Software keeps conversion clock 0.5 to 10 us
// [RQ8] Converter powered only while power enable high
// [RQ9] Software waits settling delay after power on
// [RQ10] Software clears power enable when idle
// [RQ11] Sampling phase lasts four conversion clocks
// [RQ12] Conversion phase lasts twelve conversion clocks
// [RQ13] Conversion runs autonomously without stalling processor
// [RQ14] Result readable once busy goes low
// [RQ15] Power off mid-conversion aborts without flag
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int SAMPLE_TICKS = `ADCSQ_SAMPLE_TICKS,
  parameter int RES_W        = `ADCSQ_CONV_TICKS
) (
  input  wire logic                      I_CLK,              // System clock, 250 MHz
  input  wire logic                      I_RESET_N,          // Synchronous reset, active low
  input  wire logic                      I_POWER_EN,         // Converter power enable
  input  wire logic                      I_START,            // Start control bit
  input  wire logic [`ADCSQ_SEL_W-1:0]   I_DIV_SEL,          // Conversion clock divider select
  input  wire logic                      I_INT_EN,           // Converter interrupt enable
  input  wire logic                      I_INT_FLAG_CLR,     // Clear request flag, pulse
  input  wire logic                      I_SAR_CMP,          // Comparator: input >= trial
  output logic                           O_BUSY,             // Conversion busy flag
  output logic                           O_INT_FLAG,         // Interrupt request flag
  output logic                           O_INT_REQ,          // Internal interrupt request
  output logic [`ADCSQ_BYTE_W-1:0]       O_RESULT_HIGH_BYTE, // Result upper bits
  output logic [`ADCSQ_BYTE_W-1:0]       O_RESULT_LOW_BYTE,  // Result lower byte
  output logic [RES_W-1:0]               O_SAR_TRIAL,        // Trial code to DAC
  output logic                           O_SAMPLE,           // Sample switch closed
  output logic                           O_ANALOG_POWER      // Analog circuitry powered
);

  adcsq_tick_if tk ();

  adcsq_state_t                 state_q;
  logic                         start_q;
  logic                         start_fall;
  logic                         start_rise;
  logic                         launch;
  logic                         abort;
  logic                         sample_end;
  logic                         done;
  logic [`ADCSQ_CNT_W-1:0]      samp_cnt_q;
  logic [RES_W-1:0]             bit_q;
  logic [RES_W-1:0]             trial_q;
  logic [RES_W-1:0]             trial_d;
  logic [RES_W-1:0]             result_q;
  logic [`ADCSQ_SEL_W-1:0]      sel_q;
  logic                         busy_q;
  logic                         flag_q;
  logic                         req_q;
  logic                         sample_q;
  logic                         power_q;
  logic [`ADCSQ_BUSYCNT_W-1:0]  busy_cnt_q;

  adcsq_clkdiv u_div (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .tk        (tk)
  );

  //----------------------------------------------------------------
  // Start pulse detection
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      start_q <= 1'b0;
    end else begin
      start_q <= I_START;
    end
  end

  assign start_fall = start_q && !I_START;
  assign start_rise = !start_q && I_START;
  // Trigger only on the falling end of a full pulse while powered
  assign launch     = start_fall && I_POWER_EN && (state_q == ST_IDLE); // [RQ1] [RQ8]
  // Power loss or a new rising start resets the converter
  assign abort      = (state_q != ST_IDLE) && (!I_POWER_EN || start_rise); // [RQ15]
  assign sample_end = (state_q == ST_SAMPLE) && tk.tick
                      && (samp_cnt_q == `ADCSQ_CNT_W'(SAMPLE_TICKS - 1)); // [RQ11]
  assign done       = (state_q == ST_CONVERT) && tk.tick && bit_q[0] && !abort; // [RQ12]

  assign tk.restart = launch;
  assign tk.sel     = sel_q;

  //----------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------
  // Runs on its own once launched, processor never waits
  always_ff @(posedge I_CLK) begin // [RQ13]
    if (!I_RESET_N) begin
      state_q <= ST_IDLE;
    end else if (abort) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (sample_end) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      sel_q <= '0;
    end else if (launch) begin
      sel_q <= I_DIV_SEL; // [RQ6]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || launch) begin
      samp_cnt_q <= '0;
    end else if ((state_q == ST_SAMPLE) && tk.tick) begin
      samp_cnt_q <= samp_cnt_q + 1'b1; // [RQ11]
    end
  end

  //----------------------------------------------------------------
  // Successive approximation, one bit per conversion clock
  //----------------------------------------------------------------
  always_comb begin
    trial_d = (I_SAR_CMP ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || launch || abort) begin
      bit_q   <= '0;
      trial_q <= '0;
    end else if (sample_end) begin
      bit_q   <= {1'b1, {(RES_W-1){1'b0}}};
      trial_q <= {1'b1, {(RES_W-1){1'b0}}};
    end else if ((state_q == ST_CONVERT) && tk.tick) begin
      bit_q   <= bit_q >> 1; // [RQ12]
      trial_q <= trial_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      result_q <= `ADCSQ_RESULT_RST;
    end else if (done) begin
      result_q <= trial_d; // [RQ14]
    end
  end

  //----------------------------------------------------------------
  // Status flags
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1; // [RQ2]
    end else if (done || abort) begin
      busy_q <= 1'b0; // [RQ3] [RQ15]
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1; // [RQ4]
    end else if (I_INT_FLAG_CLR) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      req_q <= 1'b0;
    end else begin
      req_q <= flag_q && I_INT_EN; // [RQ4]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      sample_q <= 1'b0;
      power_q  <= 1'b0;
    end else begin
      sample_q <= (launch || (sample_q && !sample_end)) && !abort; // [RQ11]
      power_q  <= I_POWER_EN; // [RQ8]
    end
  end

  assign O_BUSY             = busy_q;
  assign O_INT_FLAG         = flag_q;
  assign O_INT_REQ          = req_q;
  assign O_RESULT_HIGH_BYTE = `ADCSQ_BYTE_W'(result_q >> `ADCSQ_BYTE_W);
  assign O_RESULT_LOW_BYTE  = result_q[`ADCSQ_BYTE_W-1:0];
  assign O_SAR_TRIAL        = trial_q;
  assign O_SAMPLE           = sample_q;
  assign O_ANALOG_POWER     = power_q;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || !busy_q) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1'b1;
    end
  end

  property p_start_busy;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (start_q && !I_START && I_POWER_EN && !O_BUSY) |=> O_BUSY;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set by start"); // [RQ2]

  property p_busy_cause;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(O_BUSY) |-> $past(start_q && !I_START && I_POWER_EN);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start pulse"); // [RQ1]

  property p_length;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    done |-> (busy_cnt_q == `ADCSQ_BUSYCNT_W'(((SAMPLE_TICKS + RES_W) << sel_q) - 1));
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong"); // [RQ12]

  property p_sample_phase;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(state_q == ST_CONVERT) |-> $past(busy_cnt_q)
      == `ADCSQ_BUSYCNT_W'((SAMPLE_TICKS << sel_q) - 1);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("sampling length wrong"); // [RQ11]

  property p_done_status;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    done |=> (!O_BUSY && O_INT_FLAG
              && (O_RESULT_LOW_BYTE == $past(trial_d[`ADCSQ_BYTE_W-1:0])));
  endproperty
  a_done_status: assert property (p_done_status) else $error("completion status wrong"); // [RQ3]

  property p_irq_enabled;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (done && I_INT_EN) ##1 I_INT_EN |=> O_INT_REQ;
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("request missing"); // [RQ4]

  property p_irq_gated;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    $past(!I_INT_EN) |-> !O_INT_REQ;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("request while disabled"); // [RQ4]

  property p_power_abort;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (!I_POWER_EN && O_BUSY) |=> (!O_BUSY && !$rose(O_INT_FLAG) && !O_SAMPLE);
  endproperty
  a_power_abort: assert property (p_power_abort) else $error("abort failed"); // [RQ15]

  property p_result_hold;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    O_BUSY ##1 O_BUSY |-> $stable(result_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved while busy"); // [RQ14]

  c_done:     cover property (@(posedge I_CLK) disable iff (!I_RESET_N) done);
  c_abort:    cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
                              O_BUSY && !I_POWER_EN);
  c_irq:      cover property (@(posedge I_CLK) disable iff (!I_RESET_N) $rose(O_INT_REQ));
  c_slow_div: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
                              done && (sel_q == 3'h7));

endmodule

// ### hdl/adcsq_consts.svh
// Constants for the converter sequencer
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_SAMPLE_TICKS 4
`define ADCSQ_CONV_TICKS   12
`define ADCSQ_SEL_W        3
`define ADCSQ_DIV_W        7
`define ADCSQ_BYTE_W       8
`define ADCSQ_CNT_W        4
`define ADCSQ_BUSYCNT_W    12
`define ADCSQ_RESULT_RST   12'h000
`endif

// ### hdl/adcsq_pkg.sv
// Types for the converter sequencer
package adcsq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcsq_state_t;
endpackage

// ### hdl/adcsq_tick_if.sv
// Conversion clock tick link between sequencer and divider
`timescale 1ns/1ps
`include "adcsq_consts.svh"
interface adcsq_tick_if;
  logic                      restart;
  logic [`ADCSQ_SEL_W-1:0]   sel;
  logic                      tick;
  modport ctrl (output restart, output sel, input tick);
  modport div  (input restart, input sel, output tick);
endinterface

// ### hdl/adcsq_clkdiv.sv
// Power-of-two divider producing conversion clock ticks
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_clkdiv
  import adcsq_pkg::*;
#(
  parameter int DIV_W = `ADCSQ_DIV_W
) (
  input  wire logic     i_clk,     // System clock
  input  wire logic     i_reset_n, // Synchronous reset, active low
  adcsq_tick_if.div     tk         // Tick link
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] mask;

  // Low bits that must all be set for a tick
  function automatic logic [DIV_W-1:0] sel_mask(input logic [`ADCSQ_SEL_W-1:0] sel);
    sel_mask = DIV_W'((1 << sel) - 1);
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || tk.restart) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign mask    = sel_mask(tk.sel);
  // One tick every 2**sel system clocks after a restart
  assign tk.tick = !tk.restart && ((cnt_q & mask) == mask); // [RQ6]

endmodule

// ### verification/adcsq_top_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_top_tb
  import adcsq_pkg::*;
;
  logic                          I_CLK;
  logic                          I_RESET_N;
  logic                          I_POWER_EN;
  logic                          I_START;
  logic [`ADCSQ_SEL_W-1:0]       I_DIV_SEL;
  logic                          I_INT_EN;
  logic                          I_INT_FLAG_CLR;
  logic                          I_SAR_CMP;
  logic                          O_BUSY;
  logic                          O_INT_FLAG;
  logic                          O_INT_REQ;
  logic [`ADCSQ_BYTE_W-1:0]      O_RESULT_HIGH_BYTE;
  logic [`ADCSQ_BYTE_W-1:0]      O_RESULT_LOW_BYTE;
  logic [`ADCSQ_CONV_TICKS-1:0]  O_SAR_TRIAL;
  logic                          O_SAMPLE;
  logic                          O_ANALOG_POWER;
  int                            errors;
  int                            n_checks;
  int                            vin;
  int                            last_res;
  int                            exp_q[$];

  adcsq_top dut (
    .I_CLK              (I_CLK),
    .I_RESET_N          (I_RESET_N),
    .I_POWER_EN         (I_POWER_EN),
    .I_START            (I_START),
    .I_DIV_SEL          (I_DIV_SEL),
    .I_INT_EN           (I_INT_EN),
    .I_INT_FLAG_CLR     (I_INT_FLAG_CLR),
    .I_SAR_CMP          (I_SAR_CMP),
    .O_BUSY             (O_BUSY),
    .O_INT_FLAG         (O_INT_FLAG),
    .O_INT_REQ          (O_INT_REQ),
    .O_RESULT_HIGH_BYTE (O_RESULT_HIGH_BYTE),
    .O_RESULT_LOW_BYTE  (O_RESULT_LOW_BYTE),
    .O_SAR_TRIAL        (O_SAR_TRIAL),
    .O_SAMPLE           (O_SAMPLE),
    .O_ANALOG_POWER     (O_ANALOG_POWER)
  );

  initial begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ideal successive approximation against the hidden input
  function automatic int sar_model(input int v);
    int t;
    t = 0;
    for (int b = 11; b >= 0; b--) begin
      t = t | (1 << b);
      if (!(v >= t)) t = t & ~(1 << b);
    end
    return t;
  endfunction

  // Comparator follows the trial code just after every edge
  task automatic tick;
    @(posedge I_CLK);
    #1;
    I_SAR_CMP = (vin >= int'(O_SAR_TRIAL));
  endtask

  task automatic wait_n(input int n);
    repeat (n) tick;
  endtask

  task automatic pulse_start;
    I_START = 1'b1;
    tick;
    I_START = 1'b0;
    tick;
  endtask

  task automatic clr_flag;
    I_INT_FLAG_CLR = 1'b1;
    tick;
    I_INT_FLAG_CLR = 1'b0;
    tick;
    chk("flag_cleared", 16'h0000, O_INT_FLAG);
    chk("req_cleared", 16'h0000, O_INT_REQ);
  endtask

  task automatic run_conv(input int sel, input logic ien);
    int busy_n;
    int samp_n;
    int res;
    vin = $urandom_range(4095);
    I_INT_EN = ien;
    I_DIV_SEL = sel[2:0];
    clr_flag;
    exp_q.push_back(sar_model(vin));
    pulse_start;
    I_DIV_SEL = 3'($urandom);
    busy_n = 0;
    samp_n = 0;
    while (O_BUSY === 1'b1 && busy_n < 5000) begin
      busy_n++;
      if (O_SAMPLE === 1'b1) samp_n++;
      tick;
    end
    res = exp_q.pop_front();
    last_res = res;
    chk("busy_len", 16'(16 << sel), 16'(busy_n));
    chk("sample_len", 16'(4 << sel), 16'(samp_n));
    chk("flag", 16'h0001, O_INT_FLAG);
    chk("result", 16'(res), {O_RESULT_HIGH_BYTE, O_RESULT_LOW_BYTE});
    // Trial code keeps the last decision until the next launch
    chk("trial_final", 16'(res), O_SAR_TRIAL);
    tick;
    chk("int_req", {15'h0000, ien}, O_INT_REQ);
    $display("test conversion sel %0d done", sel);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    I_RESET_N = 1'b0;
    I_POWER_EN = 1'b0;
    I_START = 1'b0;
    I_DIV_SEL = 3'h0;
    I_INT_EN = 1'b0;
    I_INT_FLAG_CLR = 1'b0;
    I_SAR_CMP = 1'b0;
    errors = 0;
    n_checks = 0;
    vin = 0;
    last_res = 0;
    void'($urandom(32'h56d7));
    repeat (6) @(posedge I_CLK);
    #1;
    I_RESET_N = 1'b1;
    tick;
    chk("rst_busy", 16'h0000, O_BUSY);
    chk("rst_flag", 16'h0000, O_INT_FLAG);
    chk("rst_result", 16'h0000, {O_RESULT_HIGH_BYTE, O_RESULT_LOW_BYTE});
    chk("rst_power", 16'h0000, O_ANALOG_POWER);
    pulse_start;
    wait_n(3);
    chk("start_unpowered", 16'h0000, O_BUSY);
    $display("test reset and unpowered start done");
    I_POWER_EN = 1'b1;
    wait_n(2);
    chk("analog_power", 16'h0001, O_ANALOG_POWER);
    wait_n(20);
    for (int s = 0; s < 8; s++) run_conv(s, s[0]);
    // Flag from the last conversion must go before the abort checks
    clr_flag;
    I_DIV_SEL = 3'h2;
    pulse_start;
    wait_n(10);
    chk("pwr_abort_armed", 16'h0001, O_BUSY);
    I_POWER_EN = 1'b0;
    wait_n(2);
    chk("pwr_abort_busy", 16'h0000, O_BUSY);
    chk("pwr_abort_flag", 16'h0000, O_INT_FLAG);
    chk("pwr_abort_res", 16'(last_res), {O_RESULT_HIGH_BYTE, O_RESULT_LOW_BYTE});
    chk("pwr_off", 16'h0000, O_ANALOG_POWER);
    $display("test power abort done");
    I_POWER_EN = 1'b1;
    wait_n(20);
    I_DIV_SEL = 3'h1;
    pulse_start;
    wait_n(8);
    chk("start_abort_armed", 16'h0001, O_BUSY);
    I_START = 1'b1;
    wait_n(2);
    chk("start_abort_busy", 16'h0000, O_BUSY);
    chk("start_abort_flag", 16'h0000, O_INT_FLAG);
    chk("start_abort_res", 16'(last_res), {O_RESULT_HIGH_BYTE, O_RESULT_LOW_BYTE});
    $display("test start abort done");
    // Slowest divider keeps the conversion clock inside its usable range
    run_conv(7, 1'b1);
    stop_test;
  end

  initial begin
    #60000;
    errors++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
